// >>> logic/sbw_pkg.sv
// Constants shared by the system-bus write and arbitration logic.
// Assumes one clock and a synchronous active-high reset.
// Operation
// - Legacy mode: each single write takes address, data, then two dummy cycles.
// - Legacy mode: a write starts only after write_accept_n low two cycles earlier.
// - Reissue mode: write completes only if write_accept_n is also low at address.
// - Pipeline mode: address/data pairs back to back, each needing accept two earlier.
// - Block write: command and address, then one strobed data cycle per beat.
// - Block writes follow the same three flow-control modes as single writes.
// - Agent requests the bus; device answers with handover and releases buses.
// - Device starts no new requests while asserted, finishing current work before release.
// - Handover is a one-cycle pulse with both buses tri-stated.
// - Device drives its own requests one cycle after agent released buses.
// - External read and its response are never split by another request.
// - Buses stay undriven one cycle after handover before agent drives command.
// - Read answered by one strobed final-response data cycle, device keeps driving.
// - Every external read answers undefined data with error bit five set.
// - Null request: one strobed command cycle, then interface returns to master.
// - Mode field: 00 legacy, 01 reserved, 10 pipeline, 11 reissue; resets 00.
// - Block pattern bit: 0 one beat per three cycles, 1 every cycle; resets 0.
package sbw_pkg;
	localparam int SBW_CMD_W = 9;
	localparam logic [1:0] SBW_MODE_LEGACY = 2'h0;
	localparam logic [1:0] SBW_MODE_RSVD = 2'h1;
	localparam logic [1:0] SBW_MODE_PIPE = 2'h2;
	localparam logic [1:0] SBW_MODE_REISSUE = 2'h3;
	localparam logic [1:0] SBW_MODE_RESET = 2'h0;
	localparam logic SBW_PAT_SLOW = 1'h0;
	localparam logic SBW_PAT_RESET = 1'h0;
	// Dummy cycles after a legacy write and unused cycles between slow beats
	localparam logic [1:0] SBW_GAP_CYCLES = 2'h2;
	// Request kind sits in command bits 8..5
	localparam int SBW_KIND_HI = 8;
	localparam int SBW_KIND_LO = 5;
	localparam logic [3:0] SBW_KIND_READ = 4'h0;
	localparam logic [3:0] SBW_KIND_NULL = 4'h3;
	localparam int SBW_ERR_BIT = 5;
	localparam logic [8:0] SBW_CMD_IDLE = 9'h000;
	localparam logic [8:0] SBW_CMD_WRITE = 9'h040;
	localparam logic [8:0] SBW_DID_MORE = 9'h100;
	localparam logic [8:0] SBW_DID_LAST = 9'h180;
	localparam logic [8:0] SBW_DID_RESP_ERR = 9'h1E0;
	typedef enum logic [3:0] {
		SBW_IDLE, SBW_ADDR, SBW_DATA, SBW_BEAT_GAP, SBW_DUMMY,
		SBW_HANDOVER, SBW_SLAVE, SBW_RESP_GAP, SBW_RESP, SBW_RETURN_GAP
	} sbw_state_t;
endpackage

// >>> logic/sbw_beat_mem.sv
// Small beat store for block writes, registered read port.
// Writer must not touch an entry while a block write is reading it.
`timescale 1ns/1ps
module sbw_beat_mem #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8,
	parameter int IDX_W = 3
) (
	input wire logic clock,
	input wire logic wr_en,
	input wire logic [IDX_W-1:0] wr_index,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [IDX_W-1:0] rd_index,
	output logic [WIDTH-1:0] rd_data_reg
);
	logic [WIDTH-1:0] store [DEPTH];

	always_ff @(posedge clock) begin
		if (wr_en)
			store[wr_index] <= wr_data;
	end

	always_ff @(posedge clock) begin
		rd_data_reg <= store[rd_index];
	end
endmodule

// >>> logic/sbw_sysbus_write.sv
// Processor end of the multiplexed system bus: write flow control,
// block writes, bus handover, external read error answer, null request.
// Assumes all inputs are synchronous to clock; the agent keeps its own timing.
`timescale 1ns/1ps
module sbw_sysbus_write import sbw_pkg::*; #(
	parameter int AD_W = 32,
	parameter int MAX_BEATS = 8,
	parameter int IDX_W = $clog2(MAX_BEATS)
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic cfg_load,
	input wire logic [1:0] cfg_write_mode,
	input wire logic cfg_block_pattern,
	input wire logic wr_valid,
	input wire logic wr_block,
	input wire logic [IDX_W-1:0] wr_len_m1,
	input wire logic [AD_W-1:0] wr_addr,
	input wire logic [AD_W-1:0] wr_data,
	input wire logic fill_en,
	input wire logic [IDX_W-1:0] fill_index,
	input wire logic [AD_W-1:0] fill_data,
	output logic wr_taken_reg,
	output logic wr_done_reg,
	output logic [1:0] write_mode_reg,
	output logic block_pattern_reg,
	input wire logic write_accept_n,
	input wire logic agent_bus_request_n,
	input wire logic agent_strobe_n,
	input wire logic [AD_W-1:0] addr_data_in,
	output logic [AD_W-1:0] addr_data_out_reg,
	output logic addr_data_oe_n_reg,
	input wire logic [SBW_CMD_W-1:0] command_in,
	output logic [SBW_CMD_W-1:0] command_out_reg,
	output logic command_oe_n_reg,
	output logic proc_strobe_n_reg,
	output logic bus_handover_n_reg
);
	if (MAX_BEATS < 2 || AD_W < 8 || (1 << IDX_W) < MAX_BEATS)
		$error("sbw_sysbus_write: unsupported width or beat count");

	sbw_state_t state_reg, state_next;
	logic accept_d1_reg;
	logic retry_reg;
	logic [1:0] gap_reg;
	logic [IDX_W-1:0] beat_reg, beat_next;
	logic [IDX_W-1:0] left_reg;
	logic blk_reg;
	logic last_reg, last_next;
	logic [AD_W-1:0] addr_hold_reg;
	logic [AD_W-1:0] data_hold_reg;
	logic [AD_W-1:0] mem_rd_data;
	logic start_ok, issue, gap_done, legacy_like, reissue, fresh;
	logic [3:0] ext_kind;

	sbw_beat_mem #(.WIDTH(AD_W), .DEPTH(MAX_BEATS), .IDX_W(IDX_W))
		u_sbw_beat_mem (
		.clock(clock),
		.wr_en(fill_en),
		.wr_index(fill_index),
		.wr_data(fill_data),
		.rd_index(beat_next),
		.rd_data_reg(mem_rd_data)
	);

	// Reserved mode behaves as legacy, the safest spacing
	assign legacy_like = write_mode_reg == SBW_MODE_LEGACY ||
		write_mode_reg == SBW_MODE_RSVD;
	assign reissue = write_mode_reg == SBW_MODE_REISSUE;
	// Accept sampled one cycle ago means low two cycles before address
	assign start_ok = (retry_reg || wr_valid) && accept_d1_reg;
	assign gap_done = gap_reg == SBW_GAP_CYCLES - 2'h1;
	assign ext_kind = command_in[SBW_KIND_HI:SBW_KIND_LO];
	// Agent wins at a request boundary; a write in flight finishes first
	assign fresh = start_ok && agent_bus_request_n;
	assign issue = state_next == SBW_ADDR;
	assign last_next = (state_reg == SBW_ADDR) ? (left_reg == '0) :
		(left_reg == IDX_W'(1));

	always_comb begin
		state_next = state_reg;
		case (state_reg)
		SBW_IDLE: begin
			if (!agent_bus_request_n)
				state_next = SBW_HANDOVER;
			else if (start_ok)
				state_next = SBW_ADDR;
		end
		SBW_ADDR: begin
			if (reissue && write_accept_n)
				state_next = SBW_IDLE;
			else
				state_next = SBW_DATA;
		end
		SBW_DATA: begin
			if (!last_reg)
				state_next = (block_pattern_reg == SBW_PAT_SLOW) ?
					SBW_BEAT_GAP : SBW_DATA;
			else if (legacy_like)
				state_next = SBW_DUMMY;
			else if (fresh)
				state_next = SBW_ADDR;
			else
				state_next = SBW_IDLE;
		end
		SBW_BEAT_GAP: begin
			if (gap_done)
				state_next = SBW_DATA;
		end
		SBW_DUMMY: begin
			if (gap_done)
				state_next = fresh ? SBW_ADDR : SBW_IDLE;
		end
		SBW_HANDOVER: state_next = SBW_SLAVE;
		SBW_SLAVE: begin
			if (!agent_strobe_n && ext_kind == SBW_KIND_READ)
				state_next = SBW_RESP_GAP;
			else if (!agent_strobe_n && ext_kind == SBW_KIND_NULL)
				state_next = SBW_RETURN_GAP;
		end
		SBW_RESP_GAP: state_next = SBW_RESP;
		SBW_RESP: state_next = SBW_IDLE;
		SBW_RETURN_GAP: state_next = SBW_IDLE;
		default: state_next = SBW_IDLE;
		endcase
	end

	always_comb begin
		beat_next = beat_reg;
		if (issue || state_next == SBW_IDLE)
			beat_next = '0;
		else if (state_next == SBW_DATA && state_reg != SBW_ADDR)
			beat_next = beat_reg + IDX_W'(1);
		else if (state_next == SBW_DATA)
			beat_next = IDX_W'(1);
	end

	always_ff @(posedge clock) begin
		if (reset)
			state_reg <= SBW_IDLE;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			write_mode_reg <= SBW_MODE_RESET;
			block_pattern_reg <= SBW_PAT_RESET;
		end else if (cfg_load) begin
			write_mode_reg <= cfg_write_mode;
			block_pattern_reg <= cfg_block_pattern;
		end
	end

	always_ff @(posedge clock) begin
		if (reset)
			accept_d1_reg <= 1'b0;
		else
			accept_d1_reg <= !write_accept_n;
	end

	// A refused reissue write is replayed from the hold registers
	always_ff @(posedge clock) begin
		if (reset)
			retry_reg <= 1'b0;
		else if (state_reg == SBW_ADDR && reissue && write_accept_n)
			retry_reg <= 1'b1;
		else if (state_reg == SBW_ADDR)
			retry_reg <= 1'b0;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			addr_hold_reg <= '0;
			data_hold_reg <= '0;
			blk_reg <= 1'b0;
		end else if (issue && !retry_reg) begin
			addr_hold_reg <= wr_addr;
			data_hold_reg <= wr_data;
			blk_reg <= wr_block;
		end
	end

	always_ff @(posedge clock) begin
		if (reset)
			left_reg <= '0;
		else if (issue && !retry_reg)
			left_reg <= wr_block ? wr_len_m1 : '0;
		else if (state_next == SBW_DATA && state_reg != SBW_ADDR)
			left_reg <= left_reg - IDX_W'(1);
	end

	always_ff @(posedge clock) begin
		if (reset)
			beat_reg <= '0;
		else
			beat_reg <= beat_next;
	end

	always_ff @(posedge clock) begin
		if (reset)
			last_reg <= 1'b0;
		else if (state_next == SBW_DATA)
			last_reg <= last_next;
	end

	always_ff @(posedge clock) begin
		if (reset)
			gap_reg <= '0;
		else if (state_reg == SBW_BEAT_GAP || state_reg == SBW_DUMMY)
			gap_reg <= gap_reg + 2'h1;
		else
			gap_reg <= '0;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			wr_taken_reg <= 1'b0;
			wr_done_reg <= 1'b0;
		end else begin
			wr_taken_reg <= issue && !retry_reg;
			wr_done_reg <= state_next == SBW_DATA && last_next;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			addr_data_oe_n_reg <= 1'b0;
			command_oe_n_reg <= 1'b0;
		end else begin
			addr_data_oe_n_reg <= state_next == SBW_HANDOVER ||
				state_next == SBW_SLAVE || state_next == SBW_RESP_GAP ||
				state_next == SBW_RETURN_GAP;
			command_oe_n_reg <= state_next == SBW_HANDOVER ||
				state_next == SBW_SLAVE || state_next == SBW_RESP_GAP ||
				state_next == SBW_RETURN_GAP;
		end
	end

	always_ff @(posedge clock) begin
		if (reset)
			bus_handover_n_reg <= 1'b1;
		else
			bus_handover_n_reg <= state_next != SBW_HANDOVER;
	end

	always_ff @(posedge clock) begin
		if (reset)
			proc_strobe_n_reg <= 1'b1;
		else
			proc_strobe_n_reg <= !(state_next == SBW_ADDR ||
				state_next == SBW_DATA || state_next == SBW_RESP);
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			command_out_reg <= SBW_CMD_IDLE;
			addr_data_out_reg <= '0;
		end else begin
			case (state_next)
			SBW_ADDR: begin
				command_out_reg <= SBW_CMD_WRITE;
				addr_data_out_reg <= retry_reg ? addr_hold_reg : wr_addr;
			end
			SBW_DATA: begin
				command_out_reg <= last_next ? SBW_DID_LAST :
					SBW_DID_MORE;
				addr_data_out_reg <= blk_reg ? mem_rd_data :
					data_hold_reg;
			end
			SBW_RESP: begin
				// Nothing inside is readable from outside
				command_out_reg <= SBW_DID_RESP_ERR;
				addr_data_out_reg <= '0;
			end
			default: begin
				command_out_reg <= SBW_CMD_IDLE;
				addr_data_out_reg <= '0;
			end
			endcase
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	legacy_dummy_a: assert property (
		state_reg == SBW_DATA && last_reg && legacy_like
		|=> proc_strobe_n_reg [*2])
		else $error("legacy write lacks two dummy cycles");
	accept_lead_a: assert property (
		state_reg == SBW_ADDR |-> !$past(write_accept_n, 2))
		else $error("address cycle without accept two cycles before");
	reissue_retry_a: assert property (
		state_reg == SBW_ADDR && reissue && write_accept_n
		|=> state_reg == SBW_IDLE && retry_reg && proc_strobe_n_reg)
		else $error("refused reissue write not held for retry");
	pipe_back_a: assert property (
		state_reg == SBW_DATA && last_reg &&
		write_mode_reg == SBW_MODE_PIPE && fresh
		|=> !proc_strobe_n_reg && command_out_reg == SBW_CMD_WRITE)
		else $error("pipeline write not issued back to back");
	slow_beat_a: assert property (
		state_reg == SBW_DATA && !last_reg &&
		block_pattern_reg == SBW_PAT_SLOW
		|=> proc_strobe_n_reg ##1 proc_strobe_n_reg ##1 !proc_strobe_n_reg)
		else $error("slow block pattern spacing wrong");
	last_beat_a: assert property (
		command_out_reg == SBW_DID_LAST |-> !proc_strobe_n_reg &&
		state_reg == SBW_DATA && left_reg == '0)
		else $error("final identifier outside the last data beat");
	handover_pulse_a: assert property (
		!bus_handover_n_reg |-> addr_data_oe_n_reg && command_oe_n_reg
		##1 bus_handover_n_reg && addr_data_oe_n_reg)
		else $error("handover not one cycle with buses released");
	read_answer_a: assert property (
		state_reg == SBW_SLAVE && !agent_strobe_n &&
		ext_kind == SBW_KIND_READ
		|=> addr_data_oe_n_reg ##1 !proc_strobe_n_reg &&
		command_out_reg[SBW_ERR_BIT] && !addr_data_oe_n_reg)
		else $error("external read not answered with error data");
	null_return_a: assert property (
		state_reg == SBW_SLAVE && !agent_strobe_n &&
		ext_kind == SBW_KIND_NULL
		|=> command_oe_n_reg ##1 !command_oe_n_reg &&
		state_reg == SBW_IDLE)
		else $error("null request did not return to master");
	reset_master_a: assert property (disable iff (1'b0)
		$past(reset) |-> !addr_data_oe_n_reg && bus_handover_n_reg)
		else $error("not master after reset");

	legacy_single_c: cover property (state_reg == SBW_DUMMY ##2
		state_reg == SBW_ADDR);
	block_write_c: cover property (state_reg == SBW_DATA && blk_reg &&
		last_reg);
	read_error_c: cover property (state_reg == SBW_RESP);
	reissue_retry_c: cover property (retry_reg ##[1:20]
		state_reg == SBW_DATA);
endmodule

// >>> test/sbw_agent_model.sv
// System controller model for the far side of the multiplexed bus.
// Assumes the bench calls its tasks from the clock's rising edge.
`timescale 1ns/1ps
module sbw_agent_model import sbw_pkg::*; (
	input wire logic clock,
	input wire logic bus_handover_n,
	output logic write_accept_n,
	output logic agent_bus_request_n,
	output logic agent_strobe_n,
	output logic [SBW_CMD_W-1:0] command_in,
	output logic [31:0] addr_data_in,
	output logic agent_fault
);
	logic drv = 1'b0;
	logic [8:0] cmd_q = 9'h000;
	logic [31:0] pat = 32'h0000_0000;
	// Released lines change every cycle so stale values never look valid
	assign command_in = drv ? cmd_q : pat[8:0];
	assign addr_data_in = drv ? 32'h0000_0040 : pat;
	always @(posedge clock) pat <= ~pat;
	initial begin
		write_accept_n = 1'b1;
		agent_bus_request_n = 1'b1;
		agent_strobe_n = 1'b1;
		agent_fault = 1'b0;
	end
	// Every write is absorbed, except in reissue mode, where one addressed after accept is withdrawn is refused
	task accept_for(input int n);
		@(posedge clock);
		write_accept_n <= 1'b0;
		repeat (n) @(posedge clock);
		write_accept_n <= 1'b1;
	endtask
	task ext_request(input logic [3:0] kind);
		int k;
		@(posedge clock);
		agent_bus_request_n <= 1'b0;
		k = 0;
		// Device never turns slave on its own here, so wait for handover
		do begin
			@(posedge clock);
			k++;
		end while (bus_handover_n !== 1'b0 && k < 50);
		if (k == 50) agent_fault <= 1'b1;
		// One undriven cycle, then a single strobed one-word request
		@(posedge clock);
		agent_strobe_n <= 1'b0;
		cmd_q <= {kind, 5'h00};
		drv <= 1'b1;
		agent_bus_request_n <= 1'b1;
		@(posedge clock);
		agent_strobe_n <= 1'b1;
		drv <= 1'b0;
	endtask
endmodule

// >>> test/tb_sbw_sysbus_write.sv
// Self-checking bench for the system-bus write and arbitration block.
// Assumes the agent model stands on the bus side; no other drivers.
`timescale 1ns/1ps
module tb_sbw_sysbus_write import sbw_pkg::*;;
	logic clock, reset, cfg_load, cfg_block_pattern, wr_valid, wr_block;
	logic fill_en, wr_taken_reg, wr_done_reg, block_pattern_reg;
	logic [1:0] cfg_write_mode, write_mode_reg;
	logic [2:0] wr_len_m1, fill_index;
	logic [31:0] wr_addr, wr_data, fill_data, addr_data_in;
	logic [31:0] addr_data_out_reg;
	logic [8:0] command_in, command_out_reg;
	logic write_accept_n, agent_bus_request_n, agent_strobe_n, agent_fault;
	logic addr_data_oe_n_reg, command_oe_n_reg, proc_strobe_n_reg;
	logic bus_handover_n_reg, oe_prev, acc_prev, oe_hand;
	int n_mismatch = 0, samples_checked = 0;
	int cyc = 0, acc_first, ag_cyc, oe_cyc, n_hand, done_cyc;
	int st_cyc[$];
	logic [8:0] st_cmd[$];
	logic [31:0] st_ad[$];
	sbw_sysbus_write u_sbw_sysbus_write (.clock(clock), .reset(reset),
		.cfg_load(cfg_load), .cfg_write_mode(cfg_write_mode),
		.cfg_block_pattern(cfg_block_pattern), .wr_valid(wr_valid),
		.wr_block(wr_block), .wr_len_m1(wr_len_m1), .wr_addr(wr_addr),
		.wr_data(wr_data), .fill_en(fill_en), .fill_index(fill_index),
		.fill_data(fill_data), .wr_taken_reg(wr_taken_reg),
		.wr_done_reg(wr_done_reg), .write_mode_reg(write_mode_reg),
		.block_pattern_reg(block_pattern_reg),
		.write_accept_n(write_accept_n),
		.agent_bus_request_n(agent_bus_request_n),
		.agent_strobe_n(agent_strobe_n), .addr_data_in(addr_data_in),
		.addr_data_out_reg(addr_data_out_reg),
		.addr_data_oe_n_reg(addr_data_oe_n_reg),
		.command_in(command_in), .command_out_reg(command_out_reg),
		.command_oe_n_reg(command_oe_n_reg),
		.proc_strobe_n_reg(proc_strobe_n_reg),
		.bus_handover_n_reg(bus_handover_n_reg));
	sbw_agent_model u_sbw_agent_model (.clock(clock),
		.bus_handover_n(bus_handover_n_reg),
		.write_accept_n(write_accept_n),
		.agent_bus_request_n(agent_bus_request_n),
		.agent_strobe_n(agent_strobe_n), .command_in(command_in),
		.addr_data_in(addr_data_in), .agent_fault(agent_fault));
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// Values seen here belong to the cycle that this edge closes
	always @(posedge clock) begin
		cyc++;
		if (proc_strobe_n_reg === 1'b0) begin
			st_cyc.push_back(cyc);
			st_cmd.push_back(command_out_reg);
			st_ad.push_back(addr_data_out_reg);
		end
		if (write_accept_n === 1'b0 && acc_prev === 1'b1) acc_first = cyc;
		if (addr_data_oe_n_reg === 1'b0 && oe_prev === 1'b1) oe_cyc = cyc;
		if (agent_strobe_n === 1'b0) ag_cyc = cyc;
		if (wr_done_reg === 1'b1) done_cyc = cyc;
		if (bus_handover_n_reg === 1'b0) begin
			n_hand++;
			oe_hand = addr_data_oe_n_reg & command_oe_n_reg;
		end
		acc_prev = write_accept_n;
		oe_prev = addr_data_oe_n_reg;
		if (agent_fault === 1'b1) begin
			n_mismatch++;
			finish_test();
		end
	end
	task finish_test();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task check_val(input string what, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask
	task clear_log();
		st_cyc.delete();
		st_cmd.delete();
		st_ad.delete();
	endtask
	task load_cfg(input logic [1:0] m, input logic p);
		@(posedge clock);
		cfg_load <= 1'b1;
		cfg_write_mode <= m;
		cfg_block_pattern <= p;
		@(posedge clock);
		cfg_load <= 1'b0;
		@(posedge clock);
		check_val("mode", m, write_mode_reg);
		check_val("pattern", p, block_pattern_reg);
	endtask
	// Returns in the time step where taken rises; caller may move fields
	task do_write(input logic [31:0] a, d, input logic b, input logic [2:0] n);
		int k;
		wr_addr <= a;
		wr_data <= d;
		wr_block <= b;
		wr_len_m1 <= n;
		wr_valid <= 1'b1;
		k = 0;
		while (wr_taken_reg === 1'b1 && k < 80) begin
			@(wr_taken_reg or clock);
			k++;
		end
		for (k = 0; k < 80 && wr_taken_reg !== 1'b1; k++)
			@(wr_taken_reg or clock);
		if (k == 80) begin
			n_mismatch++;
			finish_test();
		end
	endtask
	task test_reset();
		check_val("strobe", 1, proc_strobe_n_reg);
		check_val("handover", 1, bus_handover_n_reg);
		check_val("oe", 0, addr_data_oe_n_reg | command_oe_n_reg);
		check_val("mode", SBW_MODE_RESET, write_mode_reg);
		check_val("pattern", SBW_PAT_RESET, block_pattern_reg);
		$display("test reset done");
	endtask
	task test_modes();
		logic [1:0] md [4];
		int gap [4];
		md = '{SBW_MODE_LEGACY, SBW_MODE_RSVD, SBW_MODE_PIPE, SBW_MODE_REISSUE};
		gap = '{4, 4, 2, 2};
		for (int i = 0; i < 4; i++) begin
			load_cfg(md[i], 1'b1);
			clear_log();
			fork
				u_sbw_agent_model.accept_for(14);
				begin
					do_write(32'h0000_0100, 32'h0000_00A0, 1'b0, 3'h0);
					do_write(32'h0000_0104, 32'h0000_00A1, 1'b0, 3'h0);
					wr_valid <= 1'b0;
				end
			join
			repeat (8) @(posedge clock);
			check_val("first addr", 2, st_cyc[0] - acc_first);
			check_val("addr gap", gap[i], st_cyc[2] - st_cyc[0]);
			check_val("strobes", 4, st_cyc.size());
			check_val("cmd", SBW_CMD_WRITE, st_cmd[2]);
			check_val("id", SBW_DID_LAST, st_cmd[3]);
			check_val("data", 32'h0000_00A1, st_ad[3]);
			check_val("done", st_cyc[3], done_cyc);
		end
		$display("test modes done");
	endtask
	task test_block();
		int sp;
		for (int j = 0; j < 2; j++) begin
			for (int b = 0; b < 4; b++) begin
				@(posedge clock);
				fill_en <= 1'b1;
				fill_index <= b[2:0];
				fill_data <= 32'h0000_00B0 + b + 16 * j;
			end
			@(posedge clock);
			fill_en <= 1'b0;
			// Second pass runs the slow pattern under legacy spacing
			load_cfg(j ? SBW_MODE_LEGACY : SBW_MODE_PIPE, j == 0);
			sp = (j == 0) ? 1 : 3;
			clear_log();
			fork
				u_sbw_agent_model.accept_for(4);
				begin
					do_write(32'h0000_0200, 32'h0, 1'b1, 3'h3);
					wr_valid <= 1'b0;
				end
			join
			repeat (16) @(posedge clock);
			check_val("beats", 5, st_cyc.size());
			check_val("block done", st_cyc[4], done_cyc);
			for (int b = 0; b < 4; b++) begin
				check_val("beat cycle", 1 + sp * b, st_cyc[b+1] - st_cyc[0]);
				check_val("beat data", 32'hB0 + b + 16 * j, st_ad[b+1]);
				check_val("beat id", b == 3 ? SBW_DID_LAST : SBW_DID_MORE,
					st_cmd[b+1]);
			end
		end
		$display("test block done");
	endtask
	task test_reissue();
		load_cfg(SBW_MODE_REISSUE, 1'b1);
		clear_log();
		fork
			begin
				repeat (4) @(posedge clock);
				u_sbw_agent_model.accept_for(1);
			end
			begin
				do_write(32'h0000_0300, 32'h0000_00C3, 1'b0, 3'h0);
				wr_valid <= 1'b0;
			end
		join
		repeat (8) @(posedge clock);
		check_val("refused", 1, st_cyc.size());
		check_val("refused addr", 2, st_cyc[0] - acc_first);
		u_sbw_agent_model.accept_for(3);
		repeat (8) @(posedge clock);
		check_val("retry strobes", 3, st_cyc.size());
		check_val("retry addr cycle", acc_first + 2, st_cyc[1]);
		check_val("retry addr", 32'h0000_0300, st_ad[1]);
		check_val("retry data", 32'h0000_00C3, st_ad[2]);
		check_val("retry id", SBW_DID_LAST, st_cmd[2]);
		$display("test reissue done");
	endtask
	task test_arb();
		for (int j = 0; j < 2; j++) begin
			clear_log();
			n_hand = 0;
			u_sbw_agent_model.ext_request(j ? SBW_KIND_NULL : SBW_KIND_READ);
			repeat (6) @(posedge clock);
			check_val("handover", 1, n_hand);
			check_val("released", 1, oe_hand);
			check_val("drive back", ag_cyc + 2, oe_cyc);
			check_val("answers", j ? 0 : 1, st_cyc.size());
			if (j == 0) begin
				check_val("resp cycle", ag_cyc + 2, st_cyc[0]);
				check_val("resp id", SBW_DID_RESP_ERR, st_cmd[0]);
				check_val("err bit", 1, st_cmd[0][SBW_ERR_BIT]);
			end
		end
		$display("test arbitration done");
	endtask
	initial begin
		reset = 1'b1;
		cfg_load = 1'b0;
		cfg_write_mode = 2'h0;
		cfg_block_pattern = 1'b0;
		wr_valid = 1'b0;
		wr_block = 1'b0;
		wr_len_m1 = 3'h0;
		wr_addr = 32'h0;
		wr_data = 32'h0;
		fill_en = 1'b0;
		fill_index = 3'h0;
		fill_data = 32'h0;
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		test_reset();
		test_modes();
		test_block();
		test_reissue();
		test_arb();
		finish_test();
	end
endmodule
